// ==== logic/backlight_pkg.sv ====
// Shared constants of the backlight dimming interface: frame layout, defaults, timings.
// Assumes a single 40 MHz system clock; times are kept in microseconds and converted here.
package backlight_pkg;

    // Clock rate used for every time conversion
    localparam int unsigned CLK_MHZ = 40;

    // Times as printed, microseconds
    localparam int unsigned DETECT_DELAY_US  = 100;
    localparam int unsigned DETECT_LOW_US    = 260;
    localparam int unsigned DETECT_WINDOW_US = 1000;
    localparam int unsigned EN_OFF_US        = 2500;
    localparam int unsigned DIM_OFF_US       = 20000;
    localparam int unsigned BIT_TIMEOUT_US   = 1000;
    localparam int unsigned ACK_DELAY_US     = 2;
    localparam int unsigned ACK_HOLD_US      = 512;

    // Cycle counts; all figures are whole microseconds, so ceiling and floor coincide
    localparam int unsigned DETECT_DELAY_CYC  = (DETECT_DELAY_US * CLK_MHZ + 0) / 1;
    localparam int unsigned DETECT_LOW_CYC    = DETECT_LOW_US * CLK_MHZ;
    localparam int unsigned DETECT_WINDOW_CYC = DETECT_WINDOW_US * CLK_MHZ;
    localparam int unsigned EN_OFF_CYC        = EN_OFF_US * CLK_MHZ;
    localparam int unsigned DIM_OFF_CYC       = DIM_OFF_US * CLK_MHZ;
    localparam int unsigned BIT_TIMEOUT_CYC   = BIT_TIMEOUT_US * CLK_MHZ;
    localparam int unsigned ACK_DELAY_CYC     = ACK_DELAY_US * CLK_MHZ;
    localparam int unsigned ACK_HOLD_CYC      = ACK_HOLD_US * CLK_MHZ;

    // Boost switching period in system cycles
    localparam int unsigned SWITCH_PERIOD_CYC = 33;

    // Command frame layout, LSB first on the wire
    localparam int unsigned FRAME_BITS   = 24;
    localparam int unsigned ADDR_LSB     = 16;
    localparam int unsigned ACK_REQ_BIT  = 10;
    localparam int unsigned CODE_BITS    = 9;
    localparam logic [8:0]  CODE_DEFAULT = 9'h1FF;
    localparam logic [8:0]  CODE_FULL    = 9'h1FF;

    // Duty measurement: window of 511 * 2^DUTY_SHIFT cycles
    localparam int unsigned DUTY_SHIFT      = 7;
    localparam int unsigned DUTY_WINDOW_CYC = 511 << DUTY_SHIFT;

    // Interface selection state, one-hot
    typedef enum logic [4:0] {
        ST_OFF    = 5'b00001,
        ST_DELAY  = 5'b00010,
        ST_WINDOW = 5'b00100,
        ST_WIRE   = 5'b01000,
        ST_DUTY   = 5'b10000
    } mode_e;

endpackage

// ==== logic/one_wire_receiver.sv ====
// Bit decoder for one-wire brightness commands.
// Assumes lineLevel is already synchronised to clk; enable low clears all progress.
`timescale 1ns/1ps
module one_wire_receiver #(
    parameter int unsigned TIMEOUT_CYCLES = backlight_pkg::BIT_TIMEOUT_CYC
) (
    input  wire logic        clk,        // System clock
    input  wire logic        reset_n,    // Async reset, active low
    input  wire logic        enable,     // Decoding allowed
    input  wire logic        lineLevel,  // Synchronised line level
    output logic             frameValid, // One-cycle pulse per full frame
    output logic [23:0]      frameData   // Last complete frame
);
    logic        lineDly_q;
    logic [15:0] lowCnt_q;
    logic [15:0] highCnt_q;
    logic        armed_q;
    logic [4:0]  bitCnt_q;
    logic [23:0] shift_q;
    logic        newBit;
    logic        fallEdge;

    // Bit value from phase ratio, independent of bit rate
    assign newBit   = highCnt_q > lowCnt_q;
    assign fallEdge = lineDly_q & ~lineLevel;

    // Previous line level for edge detection
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lineDly_q <= 1'b1;
        end else begin
            lineDly_q <= lineLevel;
        end
    end

    // Phase timing, bit assembly and frame completion
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lowCnt_q   <= 16'h0000;
            highCnt_q  <= 16'h0000;
            armed_q    <= 1'b0;
            bitCnt_q   <= 5'h00;
            shift_q    <= 24'h000000;
            frameValid <= 1'b0;
            frameData  <= 24'h000000;
        end else if (!enable) begin
            lowCnt_q   <= 16'h0000;
            highCnt_q  <= 16'h0000;
            armed_q    <= 1'b0;
            bitCnt_q   <= 5'h00;
            frameValid <= 1'b0;
        end else begin
            frameValid <= 1'b0;
            if (fallEdge) begin
                lowCnt_q  <= 16'h0001;
                highCnt_q <= 16'h0000;
                armed_q   <= 1'b1;
                if (armed_q) begin
                    shift_q <= {newBit, shift_q[23:1]};
                    if (bitCnt_q == 5'(backlight_pkg::FRAME_BITS - 1)) begin
                        frameData  <= {newBit, shift_q[23:1]};
                        frameValid <= 1'b1;
                        bitCnt_q   <= 5'h00;
                        armed_q    <= 1'b0; // End-of-stream low starts no bit
                    end else begin
                        bitCnt_q <= bitCnt_q + 5'h01;
                    end
                end
            end else if (!lineLevel) begin
                if (lowCnt_q != 16'hFFFF) begin
                    lowCnt_q <= lowCnt_q + 16'h0001;
                end
            end else begin
                if (highCnt_q != 16'hFFFF) begin
                    highCnt_q <= highCnt_q + 16'h0001;
                end
                // A stalled transfer drops the partial frame
                if (highCnt_q == 16'(TIMEOUT_CYCLES)) begin
                    armed_q  <= 1'b0;
                    bitCnt_q <= 5'h00;
                end
            end
        end
    end
endmodule

// ==== logic/backlight_dimming_interface.sv ====
// Control logic of a two-channel backlight driver: interface selection, enable timing,
// one-wire command handling, duty measurement, switch current limit and thermal off.
// Assumes all pin and comparator inputs are asynchronous to sys_clk; the acknowledge
// drive is open-drain, resolved outside from ctrlLineOut and ctrlLineOe_n.
`timescale 1ns/1ps
module backlight_dimming_interface #(
    parameter logic [7:0]  DEVICE_ADDRESS    = 8'hA5, // Arbitrary value
    parameter int unsigned DETECT_LOW_CYCLES = backlight_pkg::DETECT_LOW_CYC,
    parameter int unsigned WINDOW_CYCLES     = backlight_pkg::DETECT_WINDOW_CYC,
    parameter int unsigned EN_OFF_CYCLES     = backlight_pkg::EN_OFF_CYC,
    parameter int unsigned DIM_OFF_CYCLES    = backlight_pkg::DIM_OFF_CYC,
    parameter int unsigned BIT_TIMEOUT       = backlight_pkg::BIT_TIMEOUT_CYC,
    parameter int unsigned ACK_HOLD_CYCLES   = backlight_pkg::ACK_HOLD_CYC
) (
    input  wire logic       sys_clk,          // System clock, 40 MHz
    input  wire logic       reset_n,          // Power-on reset, active low
    input  wire logic       ctrlLineIn,       // Control line level at the pin
    output logic            ctrlLineOut,      // Acknowledge drive value, always low
    output logic            ctrlLineOe_n,     // Low while pulling the line low
    input  wire logic       dimPin,           // Dimming pin level
    input  wire logic       supplyOk,         // Supply above lockout level
    input  wire logic       overCurrent,      // Inductor current at limit
    input  wire logic       overTemp,         // Thermal comparator, hysteresis outside
    output logic            deviceOn,         // Device running
    output logic            oneWireMode,      // One-wire interface selected
    output logic [8:0]      brightnessCode,   // Stored one-wire code
    output logic [8:0]      channelLevel,     // Channel current in 1/511 of full scale
    output logic            switchGate        // Boost switch on
);
    localparam int CW = 20;

    // Synchronisers: stage one is read only by stage two
    logic [4:0] syncA_q;
    logic [4:0] syncB_q;
    logic       enLvl;
    logic       dimLvl;
    logic       supLvl;
    logic       ocLvl;
    logic       hotLvl;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            syncA_q <= 5'h00;
            syncB_q <= 5'h00;
        end else begin
            syncA_q <= {overTemp, overCurrent, supplyOk, dimPin, ctrlLineIn};
            syncB_q <= syncA_q;
        end
    end

    assign enLvl  = syncB_q[0];
    assign dimLvl = syncB_q[1];
    assign supLvl = syncB_q[2];
    assign ocLvl  = syncB_q[3];
    assign hotLvl = syncB_q[4];

    // Previous control level for the end of the detection pulse
    logic enDly_q;
    logic enRise;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            enDly_q <= 1'b0;
        end else begin
            enDly_q <= enLvl;
        end
    end

    assign enRise = enLvl & ~enDly_q;

    backlight_pkg::mode_e state_q;
    logic [CW-1:0]        winCnt_q;
    logic [CW-1:0]        detLowCnt_q;
    logic [CW-1:0]        enLowCnt_q;
    logic [CW-1:0]        dimLowCnt_q;
    logic                 acking;
    logic                 startOk;
    logic                 shutOff;

    // Start needs supply, both pins and no thermal fault
    assign startOk = supLvl & enLvl & dimLvl & ~hotLvl;
    // Disable conditions checked in every running state
    assign shutOff = ~supLvl | hotLvl
                   | (enLowCnt_q > CW'(EN_OFF_CYCLES))
                   | (dimLowCnt_q > CW'(DIM_OFF_CYCLES));

    // Interface selection; every start from shutdown runs detection again
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q  <= backlight_pkg::ST_OFF;
            winCnt_q <= '0;
        end else begin
            unique case (state_q)
                backlight_pkg::ST_OFF: begin
                    winCnt_q <= '0;
                    if (startOk) begin
                        state_q <= backlight_pkg::ST_DELAY;
                    end
                end
                backlight_pkg::ST_DELAY: begin
                    winCnt_q <= winCnt_q + 1'b1;
                    if (shutOff) begin
                        state_q <= backlight_pkg::ST_OFF;
                    end else if (winCnt_q == CW'(backlight_pkg::DETECT_DELAY_CYC - 1)) begin
                        state_q <= backlight_pkg::ST_WINDOW;
                    end
                end
                backlight_pkg::ST_WINDOW: begin
                    winCnt_q <= winCnt_q + 1'b1;
                    if (shutOff) begin
                        state_q <= backlight_pkg::ST_OFF;
                    end else if (enRise && dimLvl
                                 && detLowCnt_q > CW'(DETECT_LOW_CYCLES)) begin
                        state_q <= backlight_pkg::ST_WIRE;
                    end else if (winCnt_q >= CW'(WINDOW_CYCLES - 1)) begin
                        state_q <= backlight_pkg::ST_DUTY;
                    end
                end
                backlight_pkg::ST_WIRE,
                backlight_pkg::ST_DUTY: begin
                    if (shutOff) begin
                        state_q <= backlight_pkg::ST_OFF;
                    end
                end
            endcase
        end
    end

    // Length of the detection low pulse, counted only inside the window
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            detLowCnt_q <= '0;
        end else if (state_q == backlight_pkg::ST_WINDOW && !enLvl) begin
            if (detLowCnt_q != {CW{1'b1}}) begin
                detLowCnt_q <= detLowCnt_q + 1'b1;
            end
        end else if (enLvl) begin
            detLowCnt_q <= '0;
        end
    end

    // Disable timers; own acknowledge drive is not a master low
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            enLowCnt_q  <= '0;
            dimLowCnt_q <= '0;
        end else begin
            if (enLvl || acking || state_q == backlight_pkg::ST_OFF) begin
                enLowCnt_q <= '0;
            end else if (enLowCnt_q != {CW{1'b1}}) begin
                enLowCnt_q <= enLowCnt_q + 1'b1;
            end
            if (dimLvl || state_q == backlight_pkg::ST_OFF) begin
                dimLowCnt_q <= '0;
            end else if (dimLowCnt_q != {CW{1'b1}}) begin
                dimLowCnt_q <= dimLowCnt_q + 1'b1;
            end
        end
    end

    // Command reception, idle while the device drives its acknowledge
    logic        frameValid;
    logic [23:0] frameData;
    logic        addrMatch;

    one_wire_receiver #(
        .TIMEOUT_CYCLES (BIT_TIMEOUT)
    ) receiver (
        .clk        (sys_clk),
        .reset_n    (reset_n),
        .enable     (state_q == backlight_pkg::ST_WIRE && !acking),
        .lineLevel  (enLvl),
        .frameValid (frameValid),
        .frameData  (frameData)
    );

    assign addrMatch = frameData[backlight_pkg::ADDR_LSB +: 8] == DEVICE_ADDRESS;

    // Brightness store; default whenever the device is off
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            brightnessCode <= backlight_pkg::CODE_DEFAULT;
        end else if (state_q == backlight_pkg::ST_OFF) begin
            brightnessCode <= backlight_pkg::CODE_DEFAULT;
        end else if (frameValid && addrMatch) begin
            brightnessCode <= frameData[backlight_pkg::CODE_BITS-1:0];
        end
    end

    // Acknowledge: short gap after the frame, then hold the line low
    logic [CW-1:0] ackCnt_q;
    logic          ackWait_q;
    logic          ackDrive_q;

    assign acking = ackWait_q | ackDrive_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ackCnt_q   <= '0;
            ackWait_q  <= 1'b0;
            ackDrive_q <= 1'b0;
        end else if (state_q != backlight_pkg::ST_WIRE) begin
            ackCnt_q   <= '0;
            ackWait_q  <= 1'b0;
            ackDrive_q <= 1'b0;
        end else if (frameValid && addrMatch && frameData[backlight_pkg::ACK_REQ_BIT]) begin
            ackWait_q <= 1'b1;
            ackCnt_q  <= '0;
        end else if (ackWait_q) begin
            ackCnt_q <= ackCnt_q + 1'b1;
            if (ackCnt_q == CW'(backlight_pkg::ACK_DELAY_CYC - 1)) begin
                ackWait_q  <= 1'b0;
                ackDrive_q <= 1'b1;
                ackCnt_q   <= '0;
            end
        end else if (ackDrive_q) begin
            ackCnt_q <= ackCnt_q + 1'b1;
            if (ackCnt_q == CW'(ACK_HOLD_CYCLES - 1)) begin
                ackDrive_q <= 1'b0;
            end
        end
    end

    assign ctrlLineOut  = 1'b0;
    assign ctrlLineOe_n = ~ackDrive_q;

    // Duty measurement over a fixed window; a slow window trades response for no divider
    logic [15:0] dutyWin_q;
    logic [15:0] dutyHigh_q;
    logic [8:0]  dutyCode_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dutyWin_q  <= 16'h0000;
            dutyHigh_q <= 16'h0000;
            dutyCode_q <= backlight_pkg::CODE_FULL;
        end else if (state_q != backlight_pkg::ST_DUTY) begin
            dutyWin_q  <= 16'h0000;
            dutyHigh_q <= 16'h0000;
            dutyCode_q <= backlight_pkg::CODE_FULL;
        end else if (dutyWin_q == 16'(backlight_pkg::DUTY_WINDOW_CYC - 1)) begin
            dutyWin_q  <= 16'h0000;
            dutyHigh_q <= 16'h0000;
            dutyCode_q <= 9'((dutyHigh_q + {15'h0000, dimLvl}) >> backlight_pkg::DUTY_SHIFT);
        end else begin
            dutyWin_q  <= dutyWin_q + 16'h0001;
            dutyHigh_q <= dutyHigh_q + {15'h0000, dimLvl};
        end
    end

    // Channel current code from the selected interface
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            channelLevel <= 9'h000;
        end else if (state_q == backlight_pkg::ST_WIRE) begin
            channelLevel <= brightnessCode;
        end else if (state_q == backlight_pkg::ST_DUTY) begin
            channelLevel <= dutyCode_q;
        end else begin
            channelLevel <= 9'h000;
        end
    end

    assign deviceOn    = state_q == backlight_pkg::ST_WIRE || state_q == backlight_pkg::ST_DUTY;
    assign oneWireMode = state_q == backlight_pkg::ST_WIRE;

    // Switching cycle start from a divider
    logic [5:0] swCnt_q;
    logic       cycleStart;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            swCnt_q <= 6'h00;
        end else if (swCnt_q == 6'(backlight_pkg::SWITCH_PERIOD_CYC - 1)) begin
            swCnt_q <= 6'h00;
        end else begin
            swCnt_q <= swCnt_q + 6'h01;
        end
    end

    assign cycleStart = swCnt_q == 6'h00;

    // Pulse-by-pulse limit: off at the limit, on again only at the next cycle.
    // Limit outranks cycle start, so a standing overload never gives a one-cycle pulse.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            switchGate <= 1'b0;
        end else if (!deviceOn) begin
            switchGate <= 1'b0;
        end else if (ocLvl) begin
            switchGate <= 1'b0;
        end else if (cycleStart) begin
            switchGate <= 1'b1;
        end
    end
endmodule

// ==== tb/backlight_dimming_interface_asserts.sv ====
// Port checker for the backlight dimming interface.
// Bound to the top module; one clock domain, async reset.
`timescale 1ns/1ps
module backlight_dimming_interface_asserts (
    input wire logic       sys_clk,        // System clock
    input wire logic       reset_n,        // Reset, active low
    input wire logic       ctrlLineOut,    // Ack drive value
    input wire logic       ctrlLineOe_n,   // Low while pulling
    input wire logic       dimPin,         // Dimming pin
    input wire logic       supplyOk,       // Supply good
    input wire logic       overCurrent,    // Current at limit
    input wire logic       overTemp,       // Thermal flag
    input wire logic       deviceOn,       // Running
    input wire logic       oneWireMode,    // One-wire selected
    input wire logic [8:0] brightnessCode, // Stored code
    input wire logic [8:0] channelLevel,   // Channel current
    input wire logic       switchGate      // Boost switch on
);
    // Reset silences every check
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_ack_only_wire: assert property ($fell(ctrlLineOe_n) |-> oneWireMode)
        else $error("ack outside one-wire mode");
    a_ack_hold_low: assert property ($fell(ctrlLineOe_n) |=> !ctrlLineOe_n [*8])
        else $error("ack pulse too short");
    a_ack_drive_zero: assert property (!ctrlLineOe_n |-> !ctrlLineOut)
        else $error("ack drives high");
    a_code_off_default: assert property (!deviceOn && !$past(deviceOn)
        |-> brightnessCode == 9'h1FF)
        else $error("code not default while off");
    a_code_wire_only: assert property ($changed(brightnessCode)
        |-> oneWireMode || brightnessCode == 9'h1FF)
        else $error("code changed outside a frame");
    a_wire_means_on: assert property (oneWireMode |-> deviceOn)
        else $error("one-wire mode while off");
    a_start_needs_pins: assert property ($rose(deviceOn)
        |-> supplyOk && dimPin && !overTemp)
        else $error("start without enables");
    a_limit_gate_off: assert property (overCurrent [*5] |-> !switchGate)
        else $error("switch on at current limit");
    a_off_gate_level: assert property (!deviceOn [*3]
        |-> !switchGate && channelLevel == 9'h000)
        else $error("switching while off");
endmodule
bind backlight_dimming_interface backlight_dimming_interface_asserts u_chk (.sys_clk,
    .reset_n, .ctrlLineOut, .ctrlLineOe_n, .dimPin, .supplyOk, .overCurrent, .overTemp,
    .deviceOn, .oneWireMode, .brightnessCode, .channelLevel, .switchGate);

// ==== tb/one_wire_master.sv ====
// Behavioural host driving the control line open-drain with a pull-up.
// Tasks are called by the bench; all changes land at rising clock edges.
`timescale 1ns/1ps
module one_wire_master (
    input  wire logic clk,     // System clock
    input  wire logic devOut,  // Device drive value
    input  wire logic devOe_n, // Device pulls when low
    output logic      line     // Resolved line level
);
    logic pullLow = 1'b1; // Held low until the enabling edge

    // Pull-up wins unless someone pulls; open drain makes ack legal
    assign line = !(pullLow || (!devOe_n && !devOut));

    // Level for n cycles
    task automatic drive(input logic lvl, input int n);
        @(posedge clk) pullLow <= !lvl;
        repeat (n - 1) @(posedge clk);
    endtask

    // Rising edge, wait past the delay, low longer than the detect time
    task automatic select_wire;
        drive(1'b1, 4100);
        drive(1'b0, 60);
        drive(1'b1, 20);
    endtask

    // Bits LSB first, high longer for a one, closing fall, then release
    task automatic send(input logic [23:0] f, input int u, input int nb);
        for (int i = 0; i < nb; i++) begin
            drive(1'b0, f[i] ? u : 2 * u);
            drive(1'b1, f[i] ? 2 * u : u);
        end
        drive(1'b0, 10);
        drive(1'b1, 1);
    endtask
endmodule

// ==== tb/backlight_dimming_interface_bench.sv ====
// Self-checking bench of the backlight dimming interface.
// The host model owns the control line; other pins are driven here.
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin errorCnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module backlight_dimming_interface_bench;
    localparam logic [7:0] ADDR = 8'h5C; // Arbitrary value
    logic       sys_clk     = 1'b0;
    logic       reset_n     = 1'b0;
    logic       dimPin      = 1'b0;
    logic       supplyOk    = 1'b0;
    logic       overCurrent = 1'b0;
    logic       overTemp    = 1'b0;
    logic       ctrlLine;
    logic       ctrlOut;
    logic       ctrlOe_n;
    logic       on;
    logic       wire1;
    logic       gate;
    logic [8:0] code;
    logic [8:0] level;
    int         errorCnt    = 0;
    int         nTests      = 0;

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    // Short counts keep the run brief; delay and acknowledge hold keep their real length
    backlight_dimming_interface #(.DEVICE_ADDRESS(ADDR), .DETECT_LOW_CYCLES(40),
        .WINDOW_CYCLES(4400), .EN_OFF_CYCLES(300), .DIM_OFF_CYCLES(500),
        .BIT_TIMEOUT(400)) u_dut (.sys_clk(sys_clk),
        .reset_n(reset_n), .ctrlLineIn(ctrlLine), .ctrlLineOut(ctrlOut),
        .ctrlLineOe_n(ctrlOe_n), .dimPin(dimPin), .supplyOk(supplyOk),
        .overCurrent(overCurrent), .overTemp(overTemp), .deviceOn(on),
        .oneWireMode(wire1), .brightnessCode(code), .channelLevel(level),
        .switchGate(gate));
    one_wire_master u_master (.clk(sys_clk), .devOut(ctrlOut), .devOe_n(ctrlOe_n),
        .line(ctrlLine));

    // Wait n edges, then sample settled outputs
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Spare bits go out as zero
    function automatic logic [23:0] mk(input logic ack, input logic [8:0] c);
        return {ADDR, 5'h00, ack, 1'b0, c};
    endfunction

    task automatic t_wire;
        int k = 0;
        `CHK(code, 9'h1FF)
        @(posedge sys_clk) supplyOk <= 1'b1;
        dimPin <= 1'b1;
        cyc(20);
        `CHK(on, 1'b0)
        u_master.select_wire;
        cyc(5);
        `CHK(wire1, 1'b1)
        u_master.send(mk(1'b0, 9'h0A5), 25, 24);
        cyc(10);
        `CHK(code, 9'h0A5)
        `CHK(level, 9'h0A5)
        u_master.send({~ADDR, 16'h0033}, 25, 24);
        u_master.send(mk(1'b0, 9'h011), 25, 10);
        cyc(500);
        `CHK(code, 9'h0A5)
        u_master.send(mk(1'b1, 9'h100), 120, 24);
        while (ctrlOe_n !== 1'b0 && k < 300) begin
            cyc(1);
            k++;
        end
        `CHK(ctrlLine, 1'b0)
        cyc(60);
        `CHK(code, 9'h100)
        cyc(backlight_pkg::ACK_HOLD_CYC);
        `CHK(ctrlLine, 1'b1)
        $display("one-wire test done");
    endtask

    task automatic t_off_on;
        int k = 0;
        u_master.drive(1'b0, 250);
        u_master.drive(1'b1, 500);
        cyc(1);
        `CHK(on, 1'b1)
        u_master.drive(1'b0, 320);
        cyc(8);
        `CHK(on, 1'b0)
        `CHK(code, 9'h1FF)
        u_master.drive(1'b1, 4500);
        cyc(2);
        `CHK(wire1, 1'b0)
        `CHK(level, 9'h1FF)
        @(posedge sys_clk) overCurrent <= 1'b1;
        cyc(8);
        `CHK(gate, 1'b0)
        @(posedge sys_clk) overCurrent <= 1'b0;
        while (gate !== 1'b1 && k < 50) begin
            cyc(1);
            k++;
        end
        `CHK(gate, 1'b1)
        $display("duty test done");
    endtask

    task automatic t_pins;
        @(posedge sys_clk) dimPin <= 1'b0;
        cyc(400);
        `CHK(on, 1'b1)
        @(posedge sys_clk) dimPin <= 1'b1;
        cyc(5);
        @(posedge sys_clk) dimPin <= 1'b0;
        cyc(520);
        `CHK(on, 1'b0)
        @(posedge sys_clk) dimPin <= 1'b1;
        cyc(4500);
        `CHK(on, 1'b1)
        @(posedge sys_clk) overTemp <= 1'b1;
        cyc(5);
        `CHK(on, 1'b0)
        @(posedge sys_clk) overTemp <= 1'b0;
        cyc(4500);
        `CHK(on, 1'b1)
        @(posedge sys_clk) supplyOk <= 1'b0;
        cyc(5);
        `CHK(on, 1'b0)
        $display("pin test done");
    endtask

    task automatic completeRun;
        $display("tests=%0d errors=%0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Runs take about 55000 cycles; this cuts a hang
    initial begin
        repeat (100000) @(posedge sys_clk);
        errorCnt++;
        completeRun;
    end

    // Reset six cycles, then the scenarios
    initial begin
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        cyc(2);
        t_wire;
        t_off_on;
        t_pins;
        completeRun;
    end
endmodule
